/* File: tpg_top.sv */
// Test pattern generator for the camera pixel pipeline, with two injection points.
// Assumes sensor and processed streams mark frames with sof and lines with eol on one clock.
// Operation
// - Six internal test patterns can replace the normal image content.
// - A selection register picks a pattern or off; off passes sensor data.
// - Selected pattern pixels come only from internal logic, never sensor data.
// - Gain, black level and exposure have no effect on pattern pixels.
// - Patterns 1, 2, 3 and 6 are injected after digital processing.
// - Patterns 4 and 5 are injected before digital processing.
// - Pattern 1 pixel is column plus row modulo 256.
// - Pattern 1 is stationary and spans zero to 255.
// - Frame counter steps by one on each acquisition start.
// - Pattern 2 pixel is column plus row plus counter modulo 256.
// - Pattern 3 pixel is column plus row plus counter modulo 4096, 12 bit.
// - Moving patterns shift one pixel right to left per acquisition.
// - Pattern 4 has pattern 2 values but passes through processing.
// - Pattern 5 has pattern 3 values but passes through processing.
// - Colour gradient pattern 6 exists only on colour variants.
`timescale 1ns/1ps
module tpg_top #(
   // Set to zero for monochrome builds; pattern 6 is then refused.
   parameter bit COLOR_VARIANT = 1'b1
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [tpg_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [tpg_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [tpg_pkg::DATA_W-1:0] reg_rdata,
   input wire logic acq_start,
   input wire logic sensor_valid,
   input wire tpg_pkg::tpg_pix_t sensor_pix,
   output logic pre_valid,
   output tpg_pkg::tpg_pix_t pre_pix,
   input wire logic proc_valid,
   input wire tpg_pkg::tpg_pix_t proc_pix,
   output logic proc_ready,
   output logic tx_valid,
   output tpg_pkg::tpg_pix_t tx_pix,
   input wire logic tx_ready
);
   import tpg_pkg::*;

   function automatic logic is_pre(input tpg_pattern_t sel);
      is_pre = (sel == pattern_feature_8) || (sel == pattern_feature_12);
   endfunction

   function automatic logic is_post(input tpg_pattern_t sel);
      is_post = (sel == pattern_fixed_8) || (sel == pattern_moving_8) ||
                (sel == pattern_moving_12) || (sel == pattern_color_yuv);
   endfunction

   // Pixel value from raster position and frame offset only; no sensor input reaches it.
   function automatic logic [PIX_W-1:0] pattern_value(
      input tpg_pattern_t sel,
      input logic [COORD_W-1:0] col,
      input logic [COORD_W-1:0] row,
      input logic [CNT_W-1:0] cnt
   );
      logic [COORD_W-1:0] diag;
      logic [COORD_W-1:0] moving;
      logic [MOD8_W-1:0] y8;
      logic [MOD8_W-1:0] c8;
      diag = col + row;
      moving = diag + {{(COORD_W-CNT_W){1'b0}}, cnt};
      y8 = moving[MOD8_W-1:0];
      // Chroma alternates U and V by column so a 4:2:2 sink sees a smooth diagonal hue.
      c8 = col[CHROMA_SEL_BIT] ? (y8 ^ CHROMA_FLIP) : ~y8;
      case (sel)
         pattern_fixed_8: begin
            pattern_value = {{(PIX_W-MOD8_W){1'b0}}, diag[MOD8_W-1:0]};
         end
         pattern_moving_8, pattern_feature_8: begin
            pattern_value = {{(PIX_W-MOD8_W){1'b0}}, y8};
         end
         pattern_moving_12, pattern_feature_12: begin
            pattern_value = {{(PIX_W-MOD12_W){1'b0}}, moving[MOD12_W-1:0]};
         end
         pattern_color_yuv: begin
            pattern_value = {y8, c8};
         end
         default: begin
            pattern_value = '0;
         end
      endcase
   endfunction

   tpg_pattern_t sel_r;
   tpg_pattern_t sel_nxt;
   logic [CNT_W-1:0] frame_cnt_r;
   logic [CNT_W-1:0] frame_cnt_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic pre_valid_r;
   tpg_pix_t pre_pix_r;
   logic fifo_in_ready;

   // Register writes.
   wire sel_wr = reg_wr && (reg_addr == OFS_SELECT);
   wire [SEL_W-1:0] wr_code = reg_wdata[SEL_W-1:0];
   wire code_mono = (wr_code <= pattern_feature_12);
   wire code_color = COLOR_VARIANT && (wr_code == pattern_color_yuv);
   wire code_ok = code_mono || code_color;
   assign sel_nxt = (sel_wr && code_ok) ? tpg_pattern_t'(wr_code) : sel_r;

   // The counter wraps at its width, which keeps both modulo results continuous.
   assign frame_cnt_nxt = acq_start ? frame_cnt_r + CNT_ONE : frame_cnt_r;

   // Register reads; unmapped addresses read as zero.
   wire [ST_W-1:0] status_w = {is_pre(sel_r), is_post(sel_r), COLOR_VARIANT, sel_r != pattern_select_off};
   wire [DATA_W-1:0] rd_sel = {{(DATA_W-SEL_W){1'b0}}, sel_r};
   wire [DATA_W-1:0] rd_cnt = {{(DATA_W-CNT_W){1'b0}}, frame_cnt_r};
   wire [DATA_W-1:0] rd_st = {{(DATA_W-ST_W){1'b0}}, status_w};
   wire [DATA_W-1:0] rd_value = (reg_addr == OFS_SELECT) ? rd_sel :
                                (reg_addr == OFS_FRAME_COUNT) ? rd_cnt :
                                (reg_addr == OFS_STATUS) ? rd_st : '0;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sel_r <= SEL_RESET;
         frame_cnt_r <= CNT_RESET;
         rdata_r <= '0;
      end else begin
         sel_r <= sel_nxt;
         frame_cnt_r <= frame_cnt_nxt;
         rdata_r <= reg_rd ? rd_value : '0;
      end
   end

   // Raster tracking per injection point. Selection and frame offset are frozen at
   // the first pixel of a frame so that a change never tears an image in half.
   wire ch_valid [N_CH];
   wire ch_ready [N_CH];
   tpg_pix_t ch_pix [N_CH];
   logic [COORD_W-1:0] pos_col_w [N_CH];
   logic [COORD_W-1:0] pos_row_w [N_CH];
   tpg_pattern_t act_sel_w [N_CH];
   logic [CNT_W-1:0] act_off_w [N_CH];
   logic [PIX_W-1:0] gen_w [N_CH];

   assign ch_valid[CH_PRE] = sensor_valid;
   assign ch_ready[CH_PRE] = 1'b1;
   assign ch_pix[CH_PRE] = sensor_pix;
   assign ch_valid[CH_POST] = proc_valid;
   assign ch_ready[CH_POST] = fifo_in_ready;
   assign ch_pix[CH_POST] = proc_pix;

   genvar gi;
   generate
      for (gi = 0; gi < N_CH; gi++) begin : ch_g
         logic [COORD_W-1:0] col_r;
         logic [COORD_W-1:0] row_r;
         logic [CNT_W-1:0] off_r;
         tpg_pattern_t fsel_r;
         wire beat = ch_valid[gi] & ch_ready[gi];
         wire sof = ch_pix[gi].sof;
         assign pos_col_w[gi] = sof ? COORD_ZERO : col_r;
         assign pos_row_w[gi] = sof ? COORD_ZERO : row_r;
         assign act_sel_w[gi] = sof ? sel_r : fsel_r;
         assign act_off_w[gi] = sof ? frame_cnt_r : off_r;
         assign gen_w[gi] = pattern_value(act_sel_w[gi], pos_col_w[gi], pos_row_w[gi], act_off_w[gi]);
         wire [COORD_W-1:0] col_nxt = ch_pix[gi].eol ? COORD_ZERO : pos_col_w[gi] + COORD_ONE;
         wire [COORD_W-1:0] row_nxt = ch_pix[gi].eol ? pos_row_w[gi] + COORD_ONE : pos_row_w[gi];

         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               col_r <= COORD_ZERO;
               row_r <= COORD_ZERO;
               off_r <= CNT_RESET;
               fsel_r <= SEL_RESET;
            end else if (beat) begin
               col_r <= col_nxt;
               row_r <= row_nxt;
               off_r <= act_off_w[gi];
               fsel_r <= act_sel_w[gi];
            end
         end
      end
   endgenerate

   // Ahead of processing: features 4 and 5 replace sensor data, everything else passes.
   wire pre_inject = is_pre(act_sel_w[CH_PRE]);
   tpg_pix_t pre_gen;
   assign pre_gen = '{sof: sensor_pix.sof, eol: sensor_pix.eol, data: gen_w[CH_PRE]};

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pre_valid_r <= 1'b0;
         pre_pix_r <= '0;
      end else begin
         pre_valid_r <= sensor_valid;
         pre_pix_r <= sensor_valid ? (pre_inject ? pre_gen : sensor_pix) : pre_pix_r;
      end
   end

   // After processing: patterns 1, 2, 3 and 6 overwrite the processed data, so no
   // lookup table or other digital feature touches them.
   wire post_inject = is_post(act_sel_w[CH_POST]);
   tpg_pix_t post_gen;
   tpg_pix_t fifo_in;
   assign post_gen = '{sof: proc_pix.sof, eol: proc_pix.eol, data: gen_w[CH_POST]};
   assign fifo_in = post_inject ? post_gen : proc_pix;

   // The FIFO absorbs short stalls of the transmit path; when it fills, proc_ready
   // falls and the raster counters of the post point hold with it.
   tpg_fifo #(
      .WIDTH($bits(tpg_pix_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .reset_n(reset_n),
      .in_valid(proc_valid),
      .in_data(fifo_in),
      .in_ready(fifo_in_ready),
      .out_valid(tx_valid),
      .out_data(tx_pix),
      .out_ready(tx_ready)
   );

   assign reg_rdata = rdata_r;
   assign pre_valid = pre_valid_r;
   assign pre_pix = pre_pix_r;
   assign proc_ready = fifo_in_ready;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   wire post_beat = proc_valid & fifo_in_ready;
   wire [COORD_W-1:0] post_diag = pos_col_w[CH_POST] + pos_row_w[CH_POST];
   wire [COORD_W-1:0] post_move = post_diag + {{(COORD_W-CNT_W){1'b0}}, act_off_w[CH_POST]};
   wire [COORD_W-1:0] pre_move = pos_col_w[CH_PRE] + pos_row_w[CH_PRE] +
                                 {{(COORD_W-CNT_W){1'b0}}, act_off_w[CH_PRE]};

   sequence acq_seq;
      acq_start;
   endsequence

   sequence sel_read_seq;
      reg_rd && (reg_addr == OFS_SELECT);
   endsequence

   sequence frame_start_seq;
      post_beat && proc_pix.sof;
   endsequence

   sequence pre_beat_seq;
      sensor_valid && is_pre(act_sel_w[CH_PRE]);
   endsequence

   sequence bad_code_seq;
      sel_wr && !code_ok;
   endsequence

   sequence tx_stall_seq;
      tx_valid && !tx_ready;
   endsequence

   // Luma byte of the colour pattern and the column parity that picks U or V.
   wire [MOD8_W-1:0] post_y = post_move[MOD8_W-1:0];
   wire post_odd = pos_col_w[CH_POST][CHROMA_SEL_BIT];

   off_pass_a: assert property ((sensor_valid && act_sel_w[CH_PRE] == pattern_select_off) |=>
      (pre_valid && pre_pix == $past(sensor_pix)))
      else $error("sensor data not passed while patterns are off");

   sel_read_a: assert property (sel_read_seq |=> (reg_rdata[SEL_W-1:0] == $past(sel_r)))
      else $error("selection readback mismatch");

   fixed_grad_a: assert property ((post_beat && act_sel_w[CH_POST] == pattern_fixed_8) |->
      (fifo_in.data == {{(PIX_W-MOD8_W){1'b0}}, post_diag[MOD8_W-1:0]}))
      else $error("fixed gradient value wrong");

   moving8_a: assert property ((post_beat && act_sel_w[CH_POST] == pattern_moving_8) |->
      (fifo_in.data == {{(PIX_W-MOD8_W){1'b0}}, post_move[MOD8_W-1:0]}))
      else $error("moving 8 bit gradient value wrong");

   moving12_a: assert property ((post_beat && act_sel_w[CH_POST] == pattern_moving_12) |->
      (fifo_in.data == {{(PIX_W-MOD12_W){1'b0}}, post_move[MOD12_W-1:0]}))
      else $error("moving 12 bit gradient value wrong");

   feature_pre_a: assert property ((sensor_valid && act_sel_w[CH_PRE] == pattern_feature_12) |=>
      (pre_pix.data == {{(PIX_W-MOD12_W){1'b0}}, $past(pre_move[MOD12_W-1:0])}))
      else $error("feature test pattern not injected ahead of processing");

   post_pass_a: assert property ((post_beat && !is_post(act_sel_w[CH_POST])) |-> (fifo_in == proc_pix))
      else $error("processed data altered while no late pattern is selected");

   frame_step_a: assert property (acq_seq |=> (frame_cnt_r == $past(frame_cnt_r) + CNT_ONE))
      else $error("frame counter did not step on acquisition start");

   frame_hold_a: assert property (!acq_start |=> $stable(frame_cnt_r))
      else $error("frame counter moved without acquisition start");

   shift_latch_a: assert property (frame_start_seq |=> (ch_g[CH_POST].off_r == $past(frame_cnt_r)))
      else $error("frame offset not taken at start of frame");

   color_gate_a: assert property ((!COLOR_VARIANT && sel_wr && wr_code == pattern_color_yuv) |=>
      (sel_r == $past(sel_r)))
      else $error("colour pattern accepted on a monochrome build");

   pre_pass_a: assert property ((sensor_valid && !is_pre(act_sel_w[CH_PRE])) |=>
      (pre_pix == $past(sensor_pix)))
      else $error("sensor data altered without an early pattern");

   feature8_pre_a: assert property ((sensor_valid && act_sel_w[CH_PRE] == pattern_feature_8) |=>
      (pre_pix.data == {{(PIX_W-MOD8_W){1'b0}}, $past(pre_move[MOD8_W-1:0])}))
      else $error("8 bit feature pattern wrong ahead of processing");

   pre_mark_a: assert property (pre_beat_seq |=>
      (pre_pix.sof == $past(sensor_pix.sof) && pre_pix.eol == $past(sensor_pix.eol)))
      else $error("frame markers lost at the early injection point");

   color_luma_a: assert property ((post_beat && act_sel_w[CH_POST] == pattern_color_yuv) |->
      (fifo_in.data[PIX_W-1:MOD8_W] == post_y))
      else $error("colour gradient luma wrong");

   color_chroma_a: assert property ((post_beat && act_sel_w[CH_POST] == pattern_color_yuv) |->
      (fifo_in.data[MOD8_W-1:0] == (post_odd ? (post_y ^ CHROMA_FLIP) : ~post_y)))
      else $error("colour gradient chroma wrong");

   bad_code_a: assert property (bad_code_seq |=> (sel_r == $past(sel_r)))
      else $error("refused selection code was taken");

   sel_hold_a: assert property (!sel_wr |=> $stable(sel_r))
      else $error("selection moved without a write");

   rdata_idle_a: assert property (!reg_rd |=> (reg_rdata == '0))
      else $error("read data not zero outside a read");

   frame_sel_a: assert property (frame_start_seq |=> (ch_g[CH_POST].fsel_r == $past(sel_r)))
      else $error("selection not frozen at start of frame");

   tx_hold_a: assert property (tx_stall_seq |=> (tx_valid && $stable(tx_pix)))
      else $error("transmit word dropped while stalled");

   raster_hold_a: assert property ((proc_valid && !proc_ready) |=> $stable(ch_g[CH_POST].col_r))
      else $error("column moved on a refused beat");

   fixed_range_a: assert property ((post_beat && act_sel_w[CH_POST] == pattern_fixed_8) |->
      (fifo_in.data[PIX_W-1:MOD8_W] == '0))
      else $error("fixed gradient exceeds 8 bits");
endmodule

/* File: tpg_pkg.sv */
// Shared constants, types and register map of the test pattern generator.
// Assumes one pixel clock domain and the plain register port of the top module.
package tpg_pkg;

   localparam int PIX_W = 16;
   localparam int COORD_W = 16;
   localparam int CNT_W = 12;
   localparam int SEL_W = 3;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int FIFO_DEPTH = 8;
   localparam int MOD8_W = 8;
   localparam int MOD12_W = 12;

   localparam int N_CH = 2;
   localparam int CH_PRE = 0;
   localparam int CH_POST = 1;

   localparam logic [ADDR_W-1:0] OFS_SELECT = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_FRAME_COUNT = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;

   localparam int ST_ACTIVE_BIT = 0;
   localparam int ST_COLOR_BIT = 1;
   localparam int ST_POST_BIT = 2;
   localparam int ST_PRE_BIT = 3;
   localparam int ST_W = 4;

   localparam int CHROMA_SEL_BIT = 0;
   localparam logic [7:0] CHROMA_FLIP = 8'h80;
   localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
   localparam logic [COORD_W-1:0] COORD_ZERO = 16'h0000;
   localparam logic [COORD_W-1:0] COORD_ONE = 16'h0001;

   typedef enum logic [SEL_W-1:0] {
      pattern_select_off = 3'b000,
      pattern_fixed_8    = 3'b001,
      pattern_moving_8   = 3'b010,
      pattern_moving_12  = 3'b011,
      pattern_feature_8  = 3'b100,
      pattern_feature_12 = 3'b101,
      pattern_color_yuv  = 3'b110
   } tpg_pattern_t;

   localparam tpg_pattern_t SEL_RESET = pattern_select_off;

   // One pixel beat: start of frame, end of line and the pixel word.
   typedef struct packed {
      logic sof;
      logic eol;
      logic [PIX_W-1:0] data;
   } tpg_pix_t;

endpackage

/* File: tpg_fifo.sv */
// Small synchronous FIFO with a registered output stage and valid/ready on both sides.
// Assumes one clock; the drain side may stall freely, the fill side sees in_ready fall when full.
`timescale 1ns/1ps
module tpg_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
   localparam logic [CW-1:0] COUNT_ONE = CW'(1);
   localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
   localparam logic [PW-1:0] PTR_ONE = PW'(1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wptr_r;
   logic [PW-1:0] rptr_r;
   logic [CW-1:0] count_r;
   logic in_ready_r;
   logic out_valid_r;
   logic [WIDTH-1:0] out_data_r;

   wire push = in_valid & in_ready_r;
   wire load = (count_r != '0) & (~out_valid_r | out_ready);
   wire [CW-1:0] count_nxt = count_r + (push ? COUNT_ONE : '0) - (load ? COUNT_ONE : '0);
   wire [PW-1:0] wptr_nxt = (wptr_r == LAST_PTR) ? '0 : wptr_r + PTR_ONE;
   wire [PW-1:0] rptr_nxt = (rptr_r == LAST_PTR) ? '0 : rptr_r + PTR_ONE;

   // Storage carries no reset; only the pointers and count define emptiness.
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wptr_r] <= in_data;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wptr_r <= '0;
         rptr_r <= '0;
         count_r <= '0;
         in_ready_r <= 1'b1;
         out_valid_r <= 1'b0;
         out_data_r <= '0;
      end else begin
         wptr_r <= push ? wptr_nxt : wptr_r;
         rptr_r <= load ? rptr_nxt : rptr_r;
         count_r <= count_nxt;
         in_ready_r <= (count_nxt != FULL_COUNT);
         out_valid_r <= load | (out_valid_r & ~out_ready);
         out_data_r <= load ? mem[rptr_r] : out_data_r;
      end
   end

   assign in_ready = in_ready_r;
   assign out_valid = out_valid_r;
   assign out_data = out_data_r;
endmodule

/* File: tpg_pipe_model.sv */
// Behavioural model of the downstream processing stage and the transmit path.
// Assumes the pre and post ports of tpg_top and one pixel clock.
`timescale 1ns/1ps
module tpg_pipe_model
   import tpg_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic lut_en,
   input wire logic stall,
   input wire logic pre_valid,
   input wire tpg_pkg::tpg_pix_t pre_pix,
   output logic proc_valid,
   output tpg_pkg::tpg_pix_t proc_pix,
   input wire logic proc_ready,
   output logic tx_ready
);
   tpg_pix_t q[$];
   tpg_pix_t b;

   // Beats are queued here, since the sensor cannot stall while the block refuses.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q.delete();
         proc_valid <= 1'b0;
         proc_pix <= '0;
         tx_ready <= 1'b0;
      end else begin
         if (proc_valid && proc_ready) begin
            void'(q.pop_front());
         end
         if (pre_valid) begin
            b = pre_pix;
            // The lookup table stand-in inverts the low byte, so a skipped stage shows plainly.
            if (lut_en) begin
               b.data = b.data ^ 16'h00ff;
            end
            q.push_back(b);
         end
         proc_valid <= (q.size() != 0);
         // An idle bus shows a changing pattern, the inverted last beat and the last beat in turn.
         proc_pix <= (q.size() != 0) ? q[0] : ~proc_pix;
         tx_ready <= !stall;
      end
   end
endmodule

/* File: test_test_pattern_generator.sv */
// Self-checking testbench of the test pattern generator with its downstream model.
// Assumes tpg_pkg, tpg_top, tpg_fifo and tpg_pipe_model are compiled before it.
`timescale 1ns/1ps
module test_test_pattern_generator;
   import tpg_pkg::*;
   logic mclk, reset_n, reg_wr, reg_rd, acq_start, sensor_valid, lut_en, stall;
   logic pre_valid, proc_valid, proc_ready, tx_valid, tx_ready;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, mono_rdata, d, dm;
   tpg_pix_t sensor_pix, pre_pix, proc_pix, tx_pix;
   tpg_pix_t txq[$];
   int bad_count, checks, cnt_exp;

   tpg_top tpg_top_i (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acq_start(acq_start),
      .sensor_valid(sensor_valid), .sensor_pix(sensor_pix), .pre_valid(pre_valid), .pre_pix(pre_pix),
      .proc_valid(proc_valid), .proc_pix(proc_pix), .proc_ready(proc_ready), .tx_valid(tx_valid),
      .tx_pix(tx_pix), .tx_ready(tx_ready));
   // A monochrome build shares the register bus, to see the colour pattern refused.
   tpg_top #(.COLOR_VARIANT(1'b0)) tpg_top_mono_i (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(mono_rdata),
      .acq_start(acq_start), .sensor_valid(sensor_valid), .sensor_pix(sensor_pix), .pre_valid(),
      .pre_pix(), .proc_valid(1'b0), .proc_pix(proc_pix), .proc_ready(), .tx_valid(), .tx_pix(),
      .tx_ready(1'b0));
   tpg_pipe_model tpg_pipe_model_i (.mclk(mclk), .reset_n(reset_n), .lut_en(lut_en), .stall(stall),
      .pre_valid(pre_valid), .pre_pix(pre_pix), .proc_valid(proc_valid), .proc_pix(proc_pix),
      .proc_ready(proc_ready), .tx_ready(tx_ready));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         txq.push_back(tx_pix);
      end
   end

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_pix(input tpg_pix_t got, input tpg_pix_t exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so both copies are taken there.
   task automatic rd_reg(input logic [ADDR_W-1:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
      dm = mono_rdata;
   endtask

   task automatic pulse_acq(input int n);
      repeat (n) begin
         @(posedge mclk);
         acq_start <= 1'b1;
      end
      @(posedge mclk);
      acq_start <= 1'b0;
      cnt_exp = (cnt_exp + n) % 4096;
   endtask

   function automatic logic [15:0] pat_val(input int s, input int c, input int r, input int n);
      logic [15:0] y;
      y = 16'(c + r + n);
      case (s)
         1: pat_val = 16'((c + r) % 256);
         2, 4: pat_val = {8'h00, y[7:0]};
         3, 5: pat_val = {4'h0, y[11:0]};
         default: pat_val = {y[7:0], (c % 2 == 0) ? ~y[7:0] : (y[7:0] ^ 8'h80)};
      endcase
   endfunction

   task automatic drive_frame(input int w, input int h);
      for (int r = 0; r < h; r++) begin
         for (int c = 0; c < w; c++) begin
            @(posedge mclk);
            sensor_valid <= 1'b1;
            sensor_pix <= {r == 0 && c == 0, c == w - 1, 16'(16'h3c5a + r * w + c)};
         end
      end
      @(posedge mclk);
      sensor_valid <= 1'b0;
      sensor_pix <= ~sensor_pix;
   endtask

   task automatic check_frame(input int w, input int h, input int s);
      int k;
      logic [15:0] v;
      k = 0;
      while (txq.size() < w * h && k < 3000) begin
         @(posedge mclk);
         k++;
      end
      chk_reg(32'(txq.size()), 32'(w * h));
      for (int r = 0; r < h && txq.size() > 0; r++) begin
         for (int c = 0; c < w && txq.size() > 0; c++) begin
            v = (s == 0) ? 16'(16'h3c5a + r * w + c) : pat_val(s, c, r, cnt_exp);
            if (lut_en && (s == 0 || s == 4 || s == 5)) begin
               v = v ^ 16'h00ff;
            end
            chk_pix(txq.pop_front(), {r == 0 && c == 0, c == w - 1, v});
         end
      end
   endtask

   task automatic run_frame(input int s);
      wr_reg(OFS_SELECT, 32'(s));
      drive_frame(4, 3);
      check_frame(4, 3, s);
   endtask

   task automatic t_reset();
      rd_reg(OFS_SELECT);
      chk_reg(d, 32'h0000_0000);
      wr_reg(OFS_FRAME_COUNT, 32'h0000_0fff);
      rd_reg(OFS_FRAME_COUNT);
      chk_reg(d, 32'h0000_0000);
      rd_reg(OFS_STATUS);
      chk_reg(d, 32'h0000_0002);
      rd_reg(4'hc);
      chk_reg(d, 32'h0000_0000);
      $display("test reset done");
   endtask

   task automatic t_select();
      for (int s = 0; s < 7; s++) begin
         wr_reg(OFS_SELECT, 32'(s));
         rd_reg(OFS_SELECT);
         chk_reg(d, 32'(s));
         chk_reg(dm, 32'(s == 6 ? 5 : s));
         rd_reg(OFS_STATUS);
         chk_reg(d, 32'((s != 0) + 2 + ((s == 4 || s == 5) ? 8 : (s != 0) ? 4 : 0)));
      end
      wr_reg(OFS_SELECT, 32'h0000_0007);
      rd_reg(OFS_SELECT);
      chk_reg(d, 32'h0000_0006);
      chk_reg(dm, 32'h0000_0005);
      $display("test select done");
   endtask

   task automatic t_frames();
      for (int s = 0; s < 7; s++) begin
         run_frame(s);
      end
      pulse_acq(254);
      rd_reg(OFS_FRAME_COUNT);
      chk_reg(d, 32'h0000_00fe);
      for (int s = 2; s < 7; s++) begin
         run_frame(s);
      end
      pulse_acq(3840);
      run_frame(3);
      run_frame(5);
      pulse_acq(2);
      rd_reg(OFS_FRAME_COUNT);
      chk_reg(d, 32'h0000_0000);
      lut_en <= 1'b0;
      run_frame(0);
      run_frame(4);
      lut_en <= 1'b1;
      $display("test frames done");
   endtask

   task automatic t_fifo();
      wr_reg(OFS_SELECT, 32'h0000_0001);
      stall <= 1'b1;
      drive_frame(4, 4);
      repeat (10) @(posedge mclk);
      #1;
      chk_reg(32'(proc_ready), 32'h0000_0000);
      chk_reg(32'(txq.size()), 32'h0000_0000);
      stall <= 1'b0;
      check_frame(4, 4, 1);
      $display("test fifo done");
   endtask

   task automatic stop_test();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #5_000_000;
      bad_count++;
      stop_test();
   end

   initial begin
      reset_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      acq_start = 1'b0;
      sensor_valid = 1'b0;
      sensor_pix = '0;
      lut_en = 1'b1;
      stall = 1'b0;
      bad_count = 0;
      checks = 0;
      cnt_exp = 0;
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      t_reset();
      t_select();
      t_frames();
      t_fifo();
      stop_test();
   end
endmodule
